/* verilog/fes_pkg.sv */
//
// Overview of operation
// - command errors set completion error bits
// - status bit 2 reserved, reads zero
// - fault flags readable, write one clears
// - double-bit read fault sets double flag
// - single fault sets flag unless ignored or double also reported
// - ECC fault sets one flag, never both
// - read during busy block sets both
// - protection register gates program and erase
// - upper thirty bits zero; flags reset zero
//
package fes_pkg;

    // ****************************************
    // register byte offsets on the bus
    // ****************************************
    localparam logic [11:0] OFS_CMD_STATUS  = 12'h000;
    localparam logic [11:0] OFS_FAULT_FLAGS = 12'h004;
    localparam logic [11:0] OFS_PROTECTION  = 12'h008;
    localparam logic [11:0] OFS_CONFIG      = 12'h00c;
    localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h010;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_CMD_IDLE      = 7;  // command status: controller idle
    localparam int BIT_RSVD          = 2;  // command status: reserved
    localparam int BIT_DOUBLE_FAULT  = 1;  // fault flags / irq enable
    localparam int BIT_SINGLE_FAULT  = 0;  // fault flags / irq enable
    localparam int BIT_IGNORE_SF     = 0;  // config register
    localparam int BIT_PROT_OPEN     = 7;  // protection register fields
    localparam int BIT_NV_RSVD       = 6;
    localparam int BIT_HIGH_DIS      = 5;
    localparam int POS_HIGH_SIZE     = 3;
    localparam int BIT_LOW_DIS       = 2;
    localparam int POS_LOW_SIZE      = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] RST_CMD_ERR     = 2'h0;
    localparam logic [1:0] RST_FAULT_FLAGS = 2'h0;
    localparam logic [7:0] RST_PROTECTION  = 8'hff;
    localparam logic       RST_IGNORE_SF   = 1'h0;
    localparam logic [1:0] RST_IRQ_ENABLE  = 2'h0;

    // ****************************************
    // bus slave states, one-hot
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } fes_bus_state_t;

endpackage

/* verilog/fes_evt_if.sv */
`timescale 1ns/1ps
// read fault reports into the classifier and flag set pulses back out
interface fes_evt_if;
    logic rd_done;
    logic rd_single;
    logic rd_double;
    logic rd_busy;
    logic ignore_sf;
    logic set_single;
    logic set_double;

    modport classify (
        input  rd_done,
        input  rd_single,
        input  rd_double,
        input  rd_busy,
        input  ignore_sf,
        output set_single,
        output set_double
    );

    modport core (
        output rd_done,
        output rd_single,
        output rd_double,
        output rd_busy,
        output ignore_sf,
        input  set_single,
        input  set_double
    );
endinterface

/* verilog/fes_classify.sv */
`timescale 1ns/1ps
// turns one array read outcome into flag set requests
module fes_classify (
    fes_evt_if.classify evt
);
    // ****************************************
    // decode of a finished read
    // ****************************************
    // collision dominates, then double, then single; the ordering keeps
    // the two ecc outcomes exclusive even if the decoder flags both
    always_comb begin
        evt.set_single = 1'b0;
        evt.set_double = 1'b0;
        if (evt.rd_done) begin
            if (evt.rd_busy) begin
                evt.set_single = 1'b1;
                evt.set_double = 1'b1;
            end else if (evt.rd_double) begin
                evt.set_double = 1'b1;
            end else if (evt.rd_single && !evt.ignore_sf) begin
                evt.set_single = 1'b1;
            end
        end
    end
endmodule

/* verilog/fes_top.sv */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
// flash error status, command status and sector protection
module fes_top #(
    parameter int ADDR_W      = 16,       // flash array byte address width
    parameter int REGION_UNIT = 1024      // smallest protected region, bytes
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic                   PREADY,
    output logic [31:0]            PRDATA,
    output logic                   PSLVERR,
    // flash command engine
    input  wire logic              CMD_IDLE,
    input  wire logic              CMD_LAUNCH,
    input  wire logic [1:0]        CMD_ERR_SET,
    // array read outcome
    input  wire logic              RD_DONE,
    input  wire logic              RD_SINGLE,
    input  wire logic              RD_DOUBLE,
    input  wire logic              RD_BUSY,
    // protection value loaded from nonvolatile space
    input  wire logic [7:0]        PROT_NV_VALUE,
    // program / erase protection check
    input  wire logic              CHK_VALID,
    input  wire logic [ADDR_W-1:0] CHK_ADDR,
    output logic                   CHK_DONE,
    output logic                   CHK_DENY,
    // interrupt
    output logic                   IRQ
);
    // ****************************************
    // declarations
    // ****************************************
    fes_pkg::fes_bus_state_t state_reg;
    logic [1:0]  cmd_completion_err_reg;
    logic [1:0]  fault_flags_reg;
    logic [7:0]  program_flash_protection_reg;
    logic        prot_loaded_reg;
    logic        ignore_single_fault_reg;
    logic [1:0]  irq_enable_reg;
    logic [31:0] rdata_next;
    logic        map_hit;
    logic        wr_commit;
    logic        wr_lane0;
    logic [1:0]  fault_clear;
    logic [1:0]  fault_set;
    // per-register write strobes and the flags' next value
    logic [1:0]  fault_flags_next;
    logic        wr_fault_flags;
    logic        wr_protection;
    logic        wr_config;
    logic        wr_irq_enable;

    fes_evt_if evt ();

    // ****************************************
    // fault classification
    // ****************************************
    // the classifier sees the raw read outcome and the stored ignore bit
    assign evt.rd_done   = RD_DONE;
    assign evt.rd_single = RD_SINGLE;
    assign evt.rd_double = RD_DOUBLE;
    assign evt.rd_busy   = RD_BUSY;
    assign evt.ignore_sf = ignore_single_fault_reg;

    fes_classify u_classify (
        .evt (evt.classify)
    );

    // ****************************************
    // address decode, used by hit check only
    // ****************************************
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == fes_pkg::OFS_CMD_STATUS)  ||
                    (a == fes_pkg::OFS_FAULT_FLAGS) ||
                    (a == fes_pkg::OFS_PROTECTION)  ||
                    (a == fes_pkg::OFS_CONFIG)      ||
                    (a == fes_pkg::OFS_IRQ_ENABLE);
    endfunction

    // region protection test for one address
    // one bit wider than the address so the top bound 2^ADDR_W fits
    function automatic logic in_region(input logic [ADDR_W-1:0] a,
                                       input logic [1:0]        size,
                                       input logic              high);
        logic [ADDR_W:0] span;
        logic [ADDR_W:0] wide;
        span = (ADDR_W+1)'(REGION_UNIT) << size;
        wide = {1'b0, a};
        if (high) begin
            in_region = wide >= ((ADDR_W+1)'(1) << ADDR_W) - span;
        end else begin
            in_region = wide < span;
        end
    endfunction

    assign map_hit   = is_mapped(PADDR);
    // a write lands only at the edge that samples pready high
    assign wr_commit = PSEL && PENABLE && PWRITE && (state_reg == fes_pkg::ST_RESP) && map_hit;
    assign wr_lane0  = wr_commit && PSTRB[0];

    // one write strobe per writable register, shared by the update processes
    assign wr_fault_flags = wr_lane0 && (PADDR == fes_pkg::OFS_FAULT_FLAGS);
    assign wr_protection  = wr_lane0 && (PADDR == fes_pkg::OFS_PROTECTION);
    assign wr_config      = wr_lane0 && (PADDR == fes_pkg::OFS_CONFIG);
    assign wr_irq_enable  = wr_lane0 && (PADDR == fes_pkg::OFS_IRQ_ENABLE);

    // ****************************************
    // bus slave handshake, one wait state
    // ****************************************
    // the answer comes in the second access cycle whatever the address;
    // pready stands one cycle only, so a master that keeps psel and
    // penable high afterwards is taken as a fresh access phase; the
    // fixed latency keeps the slave free of any counter
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_reg <= fes_pkg::ST_IDLE;
            PREADY    <= 1'b0;
            PSLVERR   <= 1'b0;
            PRDATA    <= 32'h00000000;
        end else begin
            unique case (state_reg)
                fes_pkg::ST_IDLE: begin
                    if (PSEL && PENABLE) begin
                        state_reg <= fes_pkg::ST_RESP;
                        PREADY    <= 1'b1;
                        PSLVERR   <= !map_hit;
                        PRDATA    <= PWRITE ? 32'h00000000 : rdata_next;
                    end
                end
                fes_pkg::ST_RESP: begin
                    state_reg <= fes_pkg::ST_IDLE;
                    PREADY    <= 1'b0;
                    PSLVERR   <= 1'b0;
                    PRDATA    <= 32'h00000000;
                end
                default: begin
                    // illegal one-hot code: back to idle, answer dropped
                    state_reg <= fes_pkg::ST_IDLE;
                    PREADY    <= 1'b0;
                    PSLVERR   <= 1'b0;
                    PRDATA    <= 32'h00000000;
                end
            endcase
        end
    end

    // ****************************************
    // read mux, bits above each register read zero
    // ****************************************
    // combinational off the held address; the handshake registers it
    // into prdata so the read value stands only while pready is high;
    // the idle bit is not stored and follows the engine's level
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (PADDR)
            fes_pkg::OFS_CMD_STATUS: begin
                rdata_next[fes_pkg::BIT_CMD_IDLE] = CMD_IDLE;
                rdata_next[fes_pkg::BIT_RSVD]     = 1'b0;
                rdata_next[1:0]                   = cmd_completion_err_reg;
            end
            fes_pkg::OFS_FAULT_FLAGS: begin
                rdata_next[1:0] = fault_flags_reg;
            end
            fes_pkg::OFS_PROTECTION: begin
                rdata_next[7:0] = program_flash_protection_reg;
            end
            fes_pkg::OFS_CONFIG: begin
                rdata_next[fes_pkg::BIT_IGNORE_SF] = ignore_single_fault_reg;
            end
            fes_pkg::OFS_IRQ_ENABLE: begin
                rdata_next[1:0] = irq_enable_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // ****************************************
    // command completion error bits
    // ****************************************
    // read only: software has no way to clear these bits
    // cleared by the next command launch; a same-cycle error still sets
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cmd_completion_err_reg <= fes_pkg::RST_CMD_ERR;
        end else begin
            cmd_completion_err_reg <= ((CMD_LAUNCH ? 2'h0 : cmd_completion_err_reg)
                                      | CMD_ERR_SET);
        end
    end

    // ****************************************
    // fault flags, write one to clear
    // ****************************************
    // only lane 0 carries the flags; other lanes are ignored
    assign fault_set   = {evt.set_double, evt.set_single};
    assign fault_clear = wr_fault_flags ? PWDATA[1:0] : 2'h0;
    // set applied after clear so a colliding event is never lost
    assign fault_flags_next = (fault_flags_reg & ~fault_clear)
                              | fault_set;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            fault_flags_reg <= fes_pkg::RST_FAULT_FLAGS;
        end else begin
            fault_flags_reg <= fault_flags_next;
        end
    end

    // ****************************************
    // configuration and interrupt enables
    // ****************************************
    // the ignore bit takes effect on the next read outcome
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ignore_single_fault_reg <= fes_pkg::RST_IGNORE_SF;
            irq_enable_reg          <= fes_pkg::RST_IRQ_ENABLE;
        end else begin
            if (wr_config) begin
                ignore_single_fault_reg <= PWDATA[fes_pkg::BIT_IGNORE_SF];
            end
            if (wr_irq_enable) begin
                irq_enable_reg <= PWDATA[1:0];
            end
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    // built from the flags' next value, so the level moves at the same
    // edge as the flag itself; an enable write shows one cycle later,
    // since the enable register is read before it updates
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(fault_flags_next & irq_enable_reg);
        end
    end

    // ****************************************
    // protection register
    // ****************************************
    // reset makes everything unprotected; the nonvolatile copy is taken
    // in the first cycle after release, before software can reach it
    // program and erase checks use the loaded value from then on
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            program_flash_protection_reg <= fes_pkg::RST_PROTECTION;
            prot_loaded_reg              <= 1'b0;
        end else if (!prot_loaded_reg) begin
            program_flash_protection_reg <= PROT_NV_VALUE;
            prot_loaded_reg              <= 1'b1;
        end else if (wr_protection) begin
            // nv reserved bit is not writable
            program_flash_protection_reg[fes_pkg::BIT_NV_RSVD - 1:0] <= PWDATA[fes_pkg::BIT_NV_RSVD - 1:0];
            program_flash_protection_reg[fes_pkg::BIT_PROT_OPEN]     <= PWDATA[fes_pkg::BIT_PROT_OPEN];
        end
    end

    // ****************************************
    // program / erase protection check
    // ****************************************
    logic       prot_open_select;
    logic       high_region_prot_disable;
    logic [1:0] high_region_size;
    logic       low_region_prot_disable;
    logic [1:0] low_region_size;
    logic       hit_high;
    logic       hit_low;
    logic       in_any;

    // protection fields by name
    assign prot_open_select         = program_flash_protection_reg[fes_pkg::BIT_PROT_OPEN];
    assign high_region_prot_disable = program_flash_protection_reg[fes_pkg::BIT_HIGH_DIS];
    assign high_region_size         = program_flash_protection_reg[fes_pkg::POS_HIGH_SIZE +: 2];
    assign low_region_prot_disable  = program_flash_protection_reg[fes_pkg::BIT_LOW_DIS];
    assign low_region_size          = program_flash_protection_reg[fes_pkg::POS_LOW_SIZE +: 2];

    // region hits; a disabled region never matches
    assign hit_high = !high_region_prot_disable && in_region(CHK_ADDR, high_region_size, 1'b1);
    assign hit_low  = !low_region_prot_disable && in_region(CHK_ADDR, low_region_size, 1'b0);
    assign in_any   = hit_high || hit_low;

    // open select: regions are the protected areas; closed: regions are
    // the only unprotected areas
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CHK_DONE <= 1'b0;
            CHK_DENY <= 1'b0;
        end else begin
            CHK_DONE <= CHK_VALID;
            CHK_DENY <= CHK_VALID && (prot_open_select ? in_any : !in_any);
        end
    end
endmodule

/* bench/fes_checker.sv */
`timescale 1ns/1ps
// bus, interrupt and sector check relations seen at the top ports
module fes_checker #(
    parameter int ADDR_W      = 16,
    parameter int REGION_UNIT = 1024
) (
    // clock, reset and apb
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    // read events, sector check and interrupt
    input wire logic        RD_DONE,
    input wire logic        CHK_VALID,
    input wire logic        CHK_DONE,
    input wire logic        CHK_DENY,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ****************************************
    // assertions
    // ****************************************
    property p_ready; (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY; endproperty
    a_ready: assert property (p_ready)
        else $error("bus answer late");
    property p_rsvd; PREADY && !PWRITE && PADDR == fes_pkg::OFS_CMD_STATUS |-> !PRDATA[2]; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bit set");
    property p_upper; PREADY && !PWRITE && PADDR == fes_pkg::OFS_FAULT_FLAGS |-> PRDATA[31:2] == 0; endproperty
    a_upper: assert property (p_upper)
        else $error("unused flag bits set");
    // interrupt moves one cycle after an event or a flag clear, two after an enable write
    property p_irq_rise; $rose(IRQ) |-> $past(RD_DONE) || $past(PREADY && PWRITE, 2); endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    property p_irq_fall; $fell(IRQ) |-> $past(PREADY && PWRITE) || $past(PREADY && PWRITE, 2); endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
    property p_chk_done; CHK_VALID |=> CHK_DONE; endproperty
    a_chk_done: assert property (p_chk_done)
        else $error("sector check not answered");
    property p_chk_quiet; !CHK_VALID |=> !CHK_DONE; endproperty
    a_chk_quiet: assert property (p_chk_quiet)
        else $error("sector check answer without request");
    property p_deny; CHK_DENY |-> CHK_DONE; endproperty
    a_deny: assert property (p_deny)
        else $error("deny outside an answer");
endmodule
bind fes_top fes_checker #(.ADDR_W(ADDR_W), .REGION_UNIT(REGION_UNIT)) fes_checker_i (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PREADY(PREADY), .PRDATA(PRDATA), .RD_DONE(RD_DONE), .CHK_VALID(CHK_VALID), .CHK_DONE(CHK_DONE),
    .CHK_DENY(CHK_DENY), .IRQ(IRQ)
);

/* bench/flash_error_status_tb.sv */
`timescale 1ns/1ps
// flag and protection model against the block
module flash_error_status_tb;
    logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, irq, chk_done, chk_deny, cmd_idle = 1'b1, cmd_launch = 1'b0;
    logic [1:0]  cmd_err_set = 2'h0;
    logic        rd_done = 1'b0, rd_single = 1'b0, rd_double = 1'b0, rd_busy = 1'b0, chk_valid = 1'b0;
    logic [15:0] chk_addr = 16'h0;
    int          n_fail = 0, tests_run = 0, seed = 33299, m_flags = 0, m_cfg = 0, m_prot = 0, lo, hi, a, k;

    // 40 mhz clock
    always #12.5 clk = ~clk;

    fes_top #(.ADDR_W(16), .REGION_UNIT(1024)) fes_top_i (
        .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .CMD_IDLE(cmd_idle), .CMD_LAUNCH(cmd_launch), .CMD_ERR_SET(cmd_err_set), .RD_DONE(rd_done),
        .RD_SINGLE(rd_single), .RD_DOUBLE(rd_double), .RD_BUSY(rd_busy), .PROT_NV_VALUE(8'h6d),
        .CHK_VALID(chk_valid), .CHK_ADDR(chk_addr), .CHK_DONE(chk_done), .CHK_DENY(chk_deny), .IRQ(irq)
    );
    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready, then an idle edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(rdat, exp);
    endtask
    // one array read outcome; the model keeps busy above double above single
    task automatic ev(input logic b, input logic d, input logic s);
        rd_done <= 1'b1;
        rd_busy <= b;
        rd_double <= d;
        rd_single <= s;
        @(posedge clk);
        rd_done <= 1'b0;
        if (b) m_flags = 3;
        else if (d) m_flags = m_flags | 2;
        else if (s && !m_cfg[0]) m_flags = m_flags | 1;
    endtask
    function automatic logic deny(input int p, input int ad);
        logic hit;
        hit = (!p[5] && ad >= 65536 - (1024 << p[4:3])) || (!p[2] && ad < (1024 << p[1:0]));
        return p[7] ? hit : !hit;
    endfunction
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk(fes_pkg::OFS_FAULT_FLAGS, 32'h0);
        rdchk(fes_pkg::OFS_PROTECTION, 32'h6d);
        rdchk(fes_pkg::OFS_IRQ_ENABLE, 32'h0);
        rdchk(12'h020, 32'h0);
        check(rerr, 32'h1);
        // error bits collect until a launch; idle shows at bit 7
        for (k = 0; k < 3; k++) begin
            cmd_err_set <= (k == 0) ? 2'h2 : (k == 1) ? 2'h1 : 2'h0;
            cmd_launch <= (k == 2);
            cmd_idle <= (k == 2);
            @(posedge clk);
            cmd_err_set <= 2'h0;
            cmd_launch <= 1'b0;
            rdchk(fes_pkg::OFS_CMD_STATUS, (k == 0) ? 32'h2 : (k == 1) ? 32'h3 : 32'h80);
        end
        // double, single, busy, ignored single, double with single
        for (k = 0; k < 5; k++) begin
            m_cfg = (k == 3);
            apb(1'b1, fes_pkg::OFS_CONFIG, m_cfg);
            ev(k == 2, k == 0 || k == 4, k != 0);
            rdchk(fes_pkg::OFS_FAULT_FLAGS, m_flags);
            apb(1'b1, fes_pkg::OFS_FAULT_FLAGS, 32'h0);
            rdchk(fes_pkg::OFS_FAULT_FLAGS, m_flags);
            apb(1'b1, fes_pkg::OFS_FAULT_FLAGS, 32'h3);
            m_flags = 0;
            rdchk(fes_pkg::OFS_FAULT_FLAGS, 32'h0);
        end
        // masked single, then unmasked double raises the interrupt
        apb(1'b1, fes_pkg::OFS_IRQ_ENABLE, 32'h2);
        ev(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clk);
        check(irq, 32'h0);
        ev(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        check(irq, 32'h1);
        // a new double fault lands on the very edge of its clear
        fork
            apb(1'b1, fes_pkg::OFS_FAULT_FLAGS, 32'h3);
            begin
                repeat (2) @(posedge clk);
                ev(1'b0, 1'b1, 1'b0);
            end
        join
        m_flags = 2;
        rdchk(fes_pkg::OFS_FAULT_FLAGS, 32'h2);
        apb(1'b1, fes_pkg::OFS_FAULT_FLAGS, 32'h2);
        m_flags = 0;
        @(posedge clk);
        check(irq, 32'h0);
        // random outcomes and partial clears
        for (k = 0; k < 30; k++) begin
            m_cfg = $random(seed) & 1;
            apb(1'b1, fes_pkg::OFS_CONFIG, m_cfg);
            a = $random(seed);
            ev(a[0] & a[1], a[2], a[3]);
            rdchk(fes_pkg::OFS_FAULT_FLAGS, m_flags);
            apb(1'b1, fes_pkg::OFS_FAULT_FLAGS, a[5:4]);
            m_flags = m_flags & ~a[5:4];
        end
        // protection values, probed at both region edges and at random
        for (k = 0; k < 12; k++) begin
            a = $random(seed);
            apb(1'b1, fes_pkg::OFS_PROTECTION, a[7:0]);
            m_prot = (a & 8'hbf) | 8'h40;
            rdchk(fes_pkg::OFS_PROTECTION, m_prot);
            lo = 1024 << m_prot[1:0];
            hi = 65536 - (1024 << m_prot[4:3]);
            for (int j = 0; j < 5; j++) begin
                a = (j == 0) ? lo - 1 : (j == 1) ? lo : (j == 2) ? hi - 1 : (j == 3) ? hi : $random(seed) & 16'hffff;
                chk_valid <= 1'b1;
                chk_addr <= a[15:0];
                @(posedge clk);
                chk_valid <= 1'b0;
                @(posedge clk);
                check({chk_done, chk_deny}, {1'b1, deny(m_prot, a)});
            end
        end
        complete_run();
    end
endmodule
